// File: hdl/pps_seq.sv
// Parallel programming sequencer: strobe decoding, page buffers, arrays, fuses.
// Assumes the pins arrive asynchronously and the programmer obeys pulse widths.
//
// Function
// - Data load, select one high: flash high byte
// - Low address bits word, high bits page
// - Upper address-low bits select page when small
// - Address load, select one high: address high
// - Write strobe, select one low: program flash page
// - No-operation command clears pending write state
// - EEPROM page load then write strobe programs
// - Flash read: low byte, high by select
// - EEPROM read drives addressed byte
// - Fuse write low byte, zero programs
// - Select one high writes fuse high byte
// - Lock bits only programmed, erase clears them
// - Fuse and lock read by byte selects
// - Identification read by address low byte
// - Select one high returns calibration byte
// - Write busy lasts 3.7 to 4.5 ms
// - Chip erase busy lasts 7.5 to 9 ms
// - Action selects choose address, data, command, idle
// - Ready flag low while busy, else high
`timescale 1ns/1ps
module pps_seq
    import pps_pkg::*;
#(
    parameter int         PROG_CYCLES      = PROG_CYC,
    parameter int         ERASE_CYCLES     = ERASE_CYC,
    parameter int         FLASH_PAGE_WORDS = 16,
    parameter int         EE_PAGE_BYTES    = 4,
    parameter logic [7:0] SIG_BYTE0        = 8'h5a,  // Arbitrary value
    parameter logic [7:0] SIG_BYTE1        = 8'h3c,  // Arbitrary value
    parameter logic [7:0] SIG_BYTE2        = 8'h0f,  // Arbitrary value
    parameter logic [7:0] CAL_BYTE         = 8'h80   // Arbitrary value
)(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       load_strobe,
    input  wire logic       action_select_hi,
    input  wire logic       action_select_lo,
    input  wire logic       byte_select_one,
    input  wire logic       wr_n,
    input  wire logic       oe_n,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic            ready_busy_flag
);

    // ------------------------------------------------------------
    // Local geometry
    // ------------------------------------------------------------
    localparam int FW      = $clog2(FLASH_PAGE_WORDS);
    localparam int EW      = $clog2(EE_PAGE_BYTES);
    localparam int IW      = FLASH_AW + 1;
    localparam int CNT_W   = $clog2(ERASE_CYCLES + 1);
    localparam int FDEPTH  = 1 << FLASH_AW;
    localparam int EDEPTH  = 1 << EE_AW;

    typedef struct packed {
        pps_state_e                  st;
        logic [7:0]                  cmd;
        logic [7:0]                  addr_lo;
        logic [7:0]                  addr_hi;
        logic [7:0]                  data_lo;
        logic [7:0]                  data_hi;
        logic [7:0]                  fuse_lo;
        logic [7:0]                  fuse_hi;
        logic [7:0]                  lock;
        logic [FLASH_PAGE_WORDS-1:0] fmask;
        logic [EE_PAGE_BYTES-1:0]    emask;
        logic [IW-1:0]               idx;
        logic [CNT_W-1:0]            cnt;
        logic                        ld_q;
        logic                        wr_q;
        logic [7:0]                  dout;
        logic                        oe;
        logic                        ready;
    } pps_seq_s;

    pps_seq_s r_reg;
    pps_seq_s r_next;

    pps_pins_s              pin_raw;
    pps_pins_s              pin;
    logic                   byte_select_two;
    logic                   ld_rise;
    logic                   wr_fall;
    logic                   busy;
    logic [FLASH_AW-1:0]    faddr;
    logic                   fb_we;
    logic [FW-1:0]          fb_waddr;
    logic [15:0]            fb_rdata;
    logic                   eb_we;
    logic [EW-1:0]          eb_waddr;
    logic [7:0]             eb_rdata;
    logic                   fl_we;
    logic [FLASH_AW-1:0]    fl_waddr;
    logic [15:0]            fl_wdata;
    logic [15:0]            fl_rdata;
    logic                   ee_we;
    logic [EE_AW-1:0]       ee_waddr;
    logic [7:0]             ee_wdata;
    logic [7:0]             ee_rdata;
    logic [IW-1:0]          prev;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    assign pin_raw = '{load_strobe, wr_n, oe_n, action_select_hi,
                       action_select_lo, byte_select_one, data_in};

    pps_sync #(
        .WIDTH   ($bits(pps_pins_s)),
        .RST_VAL (PINS_IDLE)
    ) u_sync (
        .clk     (clk),
        .nrst    (nrst),
        .pin_in  (pin_raw),
        .pin_out (pin)
    );

    // Shared pin: the high action select doubles as byte select two
    assign byte_select_two = pin.action_select_hi;

    // Edge events, one per pulse
    assign ld_rise = pin.load_strobe & ~r_reg.ld_q;
    assign wr_fall = ~pin.wr_n & r_reg.wr_q;
    assign busy    = (r_reg.st != ST_IDLE);
    assign prev    = r_reg.idx - IW'(1);

    // Flash word address: page in the high bits, word in the low bits
    assign faddr = {r_reg.addr_hi[1:0], r_reg.addr_lo};

    // ------------------------------------------------------------
    // Page buffers and arrays
    // ------------------------------------------------------------
    pps_mem #(
        .WIDTH (16),
        .DEPTH (FLASH_PAGE_WORDS)
    ) u_fbuf (
        .clk   (clk),
        .nrst  (nrst),
        .we    (fb_we),
        .waddr (fb_waddr),
        .wdata ({pin.data, r_reg.data_lo}),
        .raddr (r_reg.idx[FW-1:0]),
        .rdata (fb_rdata)
    );

    pps_mem #(
        .WIDTH (8),
        .DEPTH (EE_PAGE_BYTES)
    ) u_ebuf (
        .clk   (clk),
        .nrst  (nrst),
        .we    (eb_we),
        .waddr (eb_waddr),
        .wdata (pin.data),
        .raddr (r_reg.idx[EW-1:0]),
        .rdata (eb_rdata)
    );

    pps_mem #(
        .WIDTH (16),
        .DEPTH (FDEPTH)
    ) u_flash (
        .clk   (clk),
        .nrst  (nrst),
        .we    (fl_we),
        .waddr (fl_waddr),
        .wdata (fl_wdata),
        .raddr (faddr),
        .rdata (fl_rdata)
    );

    pps_mem #(
        .WIDTH (8),
        .DEPTH (EDEPTH)
    ) u_eeprom (
        .clk   (clk),
        .nrst  (nrst),
        .we    (ee_we),
        .waddr (ee_waddr),
        .wdata (ee_wdata),
        .raddr (r_reg.addr_lo[EE_AW-1:0]),
        .rdata (ee_rdata)
    );

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb
    begin
        r_next   = r_reg;
        fb_we    = 1'b0;
        fb_waddr = faddr[FW-1:0];
        eb_we    = 1'b0;
        eb_waddr = r_reg.addr_lo[EW-1:0];
        fl_we    = 1'b0;
        fl_waddr = {faddr[FLASH_AW-1:FW], prev[FW-1:0]};
        fl_wdata = fb_rdata;
        ee_we    = 1'b0;
        ee_waddr = {r_reg.addr_lo[EE_AW-1:EW], prev[EW-1:0]};
        ee_wdata = eb_rdata;

        r_next.ld_q = pin.load_strobe;
        r_next.wr_q = pin.wr_n;
        r_next.oe   = ~pin.oe_n;

        // Busy counter runs from the write strobe regardless of walk
        if (r_reg.cnt != '0)
            r_next.cnt = r_reg.cnt - CNT_W'(1);

        // Loads ignored while busy; the programmer must wait anyway
        if (ld_rise && !busy)
        begin
            case ({pin.action_select_hi, pin.action_select_lo})
                ACT_ADDR:
                begin
                    if (pin.byte_select_one)
                        r_next.addr_hi = pin.data;
                    else
                        r_next.addr_lo = pin.data;
                end
                ACT_DATA:
                begin
                    if (pin.byte_select_one)
                    begin
                        r_next.data_hi = pin.data;
                        if (r_reg.cmd == CMD_WFLASH)
                        begin
                            fb_we                          = 1'b1;
                            r_next.fmask[faddr[FW-1:0]]    = 1'b1;
                        end
                    end
                    else
                    begin
                        r_next.data_lo = pin.data;
                        if (r_reg.cmd == CMD_WEE)
                        begin
                            eb_we                                   = 1'b1;
                            r_next.emask[r_reg.addr_lo[EW-1:0]]     = 1'b1;
                        end
                    end
                end
                ACT_CMD:
                begin
                    r_next.cmd = pin.data;
                    if (pin.data == CMD_NOP)
                    begin
                        r_next.fmask = '0;
                        r_next.emask = '0;
                    end
                end
                default: ;
            endcase
        end

        // Write strobe starts the self-timed operation of the command
        if (wr_fall && !busy)
        begin
            case (r_reg.cmd)
                CMD_WFLASH, CMD_WEE:
                begin
                    if (!pin.byte_select_one)
                    begin
                        r_next.st  = ST_PAGE;
                        r_next.idx = '0;
                        r_next.cnt = CNT_W'(PROG_CYCLES - 1);
                    end
                end
                CMD_WFUSE:
                begin
                    if (!byte_select_two)
                    begin
                        if (pin.byte_select_one)
                            r_next.fuse_hi = r_reg.data_lo;
                        else
                            r_next.fuse_lo = r_reg.data_lo;
                        r_next.st  = ST_HOLD;
                        r_next.cnt = CNT_W'(PROG_CYCLES - 1);
                    end
                end
                CMD_WLOCK:
                begin
                    r_next.lock = r_reg.lock & r_reg.data_lo;
                    r_next.st   = ST_HOLD;
                    r_next.cnt  = CNT_W'(PROG_CYCLES - 1);
                end
                CMD_ERASE:
                begin
                    r_next.st  = ST_ERASE;
                    r_next.idx = '0;
                    r_next.cnt = CNT_W'(ERASE_CYCLES - 1);
                end
                default: ;
            endcase
        end

        // Walks: page buffer read has one cycle latency, so the page write trails idx; erase writes at idx
        case (r_reg.st)
            ST_IDLE: ;
            ST_PAGE:
            begin
                r_next.idx = r_reg.idx + IW'(1);
                if (r_reg.cmd == CMD_WFLASH)
                begin
                    fl_we = (r_reg.idx != '0) && r_reg.fmask[prev[FW-1:0]];
                    if (r_reg.idx == IW'(FLASH_PAGE_WORDS))
                    begin
                        r_next.fmask = '0;
                        r_next.st    = ST_HOLD;
                    end
                end
                else
                begin
                    ee_we = (r_reg.idx != '0) && r_reg.emask[prev[EW-1:0]];
                    if (r_reg.idx == IW'(EE_PAGE_BYTES))
                    begin
                        r_next.emask = '0;
                        r_next.st    = ST_HOLD;
                    end
                end
            end
            ST_ERASE:
            begin
                // Flash and EEPROM blanked together; fuses untouched
                r_next.idx = r_reg.idx + IW'(1);
                fl_we      = 1'b1;
                fl_waddr   = r_reg.idx[FLASH_AW-1:0];
                fl_wdata   = {BLANK_BYTE, BLANK_BYTE};
                ee_we      = 1'b1;
                ee_waddr   = r_reg.idx[EE_AW-1:0];
                ee_wdata   = BLANK_BYTE;
                if (r_reg.idx == IW'(FDEPTH - 1))
                begin
                    r_next.lock  = LOCK_RST;
                    r_next.fmask = '0;
                    r_next.emask = '0;
                    r_next.st    = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (r_reg.cnt == '0)
                    r_next.st = ST_IDLE;
            end
            default: r_next.st = ST_IDLE;
        endcase

        // Read data selection by command and byte selects
        case (r_reg.cmd)
            CMD_RFLASH:
                r_next.dout = pin.byte_select_one ? fl_rdata[15:8] : fl_rdata[7:0];
            CMD_REE:
                r_next.dout = ee_rdata;
            CMD_RFUSE:
            begin
                case ({byte_select_two, pin.byte_select_one})
                    2'h0:    r_next.dout = r_reg.fuse_lo;
                    2'h3:    r_next.dout = r_reg.fuse_hi;
                    2'h1:    r_next.dout = r_reg.lock;
                    default: r_next.dout = BLANK_BYTE;
                endcase
            end
            CMD_RSIG:
            begin
                if (pin.byte_select_one)
                    r_next.dout = CAL_BYTE;
                else
                begin
                    case (r_reg.addr_lo)
                        8'h00:   r_next.dout = SIG_BYTE0;
                        8'h01:   r_next.dout = SIG_BYTE1;
                        8'h02:   r_next.dout = SIG_BYTE2;
                        default: r_next.dout = BLANK_BYTE;
                    endcase
                end
            end
            default: r_next.dout = BLANK_BYTE;
        endcase

        r_next.ready = (r_next.st == ST_IDLE);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            r_reg         <= '0;
            r_reg.st      <= ST_IDLE;
            r_reg.fuse_lo <= FUSE_LO_RST;
            r_reg.fuse_hi <= FUSE_HI_RST;
            r_reg.lock    <= LOCK_RST;
            r_reg.ld_q    <= PINS_IDLE.load_strobe;
            r_reg.wr_q    <= PINS_IDLE.wr_n;
            r_reg.dout    <= BLANK_BYTE;
            r_reg.ready   <= 1'b1;
        end
        else
            r_reg <= r_next;
    end

    // Outputs straight from flops; the pad resolves the wire from data_oe
    assign data_out        = r_reg.dout;
    assign data_oe         = r_reg.oe;
    assign ready_busy_flag = r_reg.ready;

endmodule : pps_seq

// File: hdl/pps_pkg.sv
// Shared constants and types of the parallel programming sequencer.
// Assumes a single 250 MHz clock and a synchronous active-low reset.
package pps_pkg;

    // ------------------------------------------------------------
    // Command bytes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_NOP     = 8'h00;
    localparam logic [7:0] CMD_ERASE   = 8'h80;
    localparam logic [7:0] CMD_WFUSE   = 8'h40;
    localparam logic [7:0] CMD_WLOCK   = 8'h20;
    localparam logic [7:0] CMD_WFLASH  = 8'h10;
    localparam logic [7:0] CMD_WEE     = 8'h11;
    localparam logic [7:0] CMD_RSIG    = 8'h08;
    localparam logic [7:0] CMD_RFUSE   = 8'h04;
    localparam logic [7:0] CMD_RFLASH  = 8'h02;
    localparam logic [7:0] CMD_REE     = 8'h03;

    // ------------------------------------------------------------
    // Action select codes and array geometry
    // ------------------------------------------------------------
    localparam logic [1:0] ACT_ADDR    = 2'h0;
    localparam logic [1:0] ACT_DATA    = 2'h1;
    localparam logic [1:0] ACT_CMD     = 2'h2;
    localparam int         FLASH_AW    = 10;
    localparam int         EE_AW       = 7;
    localparam int         SIG_LAST    = 2;
    localparam logic [7:0] BLANK_BYTE  = 8'hff;
    localparam logic [7:0] FUSE_LO_RST = 8'hff;
    localparam logic [7:0] FUSE_HI_RST = 8'hff;
    localparam logic [7:0] LOCK_RST    = 8'hff;

    // ------------------------------------------------------------
    // Timing: least busy times rounded up to whole cycles
    // ------------------------------------------------------------
    localparam real CLK_PERIOD_NS = 4.0;
    localparam real T_PROG_MS     = 3.7;
    localparam real T_ERASE_MS    = 7.5;
    localparam int  PROG_CYC      = int'($ceil(T_PROG_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int  ERASE_CYC     = int'($ceil(T_ERASE_MS * 1.0e6 / CLK_PERIOD_NS));

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum {ST_IDLE, ST_PAGE, ST_ERASE, ST_HOLD} pps_state_e;

    typedef struct packed {
        logic       load_strobe;
        logic       wr_n;
        logic       oe_n;
        logic       action_select_hi;
        logic       action_select_lo;
        logic       byte_select_one;
        logic [7:0] data;
    } pps_pins_s;

    localparam pps_pins_s PINS_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00};

endpackage : pps_pkg

// File: hdl/pps_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin inputs and the block clock.
`timescale 1ns/1ps
module pps_sync
    import pps_pkg::*;
#(
    parameter int               WIDTH   = 14,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } pps_sync_s;

    pps_sync_s r_reg;
    pps_sync_s r_next;

    // ------------------------------------------------------------
    // Next state: a bit changes only where stages two and three agree
    // ------------------------------------------------------------
    always_comb
    begin
        r_next    = r_reg;
        r_next.s1 = pin_in;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.q  = (r_reg.s2 & r_reg.s3) | (r_reg.q & (r_reg.s2 ^ r_reg.s3));
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
            r_reg <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        else
            r_reg <= r_next;
    end

    assign pin_out = r_reg.q;

endmodule : pps_sync

// File: hdl/pps_mem.sv
// Simple dual-port memory with registered read data.
// Assumes contents are undefined until written (erase fills them).
`timescale 1ns/1ps
module pps_mem
    import pps_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
)(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] rdata_reg;

    // ------------------------------------------------------------
    // Array write; no reset so it maps onto block memory
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (we)
            mem_reg[waddr] <= wdata;
    end

    // Registered read, old data on a same-address write
    always_ff @(posedge clk)
    begin
        if (!nrst)
            rdata_reg <= '0;
        else
            rdata_reg <= mem_reg[raddr];
    end

    assign rdata = rdata_reg;

endmodule : pps_mem

// File: tb/pps_seq_props.sv
// Timing checker of the sequencer pins.
// Bound to pps_seq; sees only its ports.
`timescale 1ns/1ps
module pps_seq_props
    import pps_pkg::*;
#(
    parameter int PROG_CYCLES  = PROG_CYC,
    parameter int ERASE_CYCLES = ERASE_CYC
)(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       wr_n,
    input wire logic       oe_n,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic       ready_busy_flag
);
    // Busy length counter; far too long for a repetition
    int busy_cnt_reg;
    always_ff @(posedge clk)
        busy_cnt_reg <= (!nrst || ready_busy_flag) ? 0 : busy_cnt_reg + 1;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence busy_start;
        $fell(ready_busy_flag);
    endsequence
    sequence oe_low;
        !oe_n [*6];
    endsequence
    rst_ready_a: assert property (disable iff (1'b0) !nrst |=> ready_busy_flag && !data_oe)
        else $error("ready or drive wrong after reset");
    rst_out_a: assert property (disable iff (1'b0) !nrst |=> data_out == 8'hff)
        else $error("read byte not blank after reset");
    oe_drive_a: assert property (oe_low |-> data_oe)
        else $error("bus not driven while output enabled");
    oe_release_a: assert property (oe_n [*6] |-> !data_oe)
        else $error("bus driven while output disabled");
    busy_cause_a: assert property (busy_start |-> !$past(wr_n, 4))
        else $error("busy without write strobe");
    busy_hold_a: assert property (busy_start |=> !ready_busy_flag [*8])
        else $error("busy pulse too short");
    busy_len_a: assert property ($rose(ready_busy_flag) |-> busy_cnt_reg inside
        {[PROG_CYCLES - 1:PROG_CYCLES + 1], [ERASE_CYCLES - 1:ERASE_CYCLES + 1]})
        else $error("busy length wrong");
    busy_cap_a: assert property (busy_cnt_reg <= ERASE_CYCLES + 1)
        else $error("busy longer than erase time");
endmodule : pps_seq_props

// File: tb/pps_prog_model.sv
// Programmer model: drives the pin bundle with legal strobe timing.
// Assumes the bench closes the data bus loop.
`timescale 1ns/1ps
module pps_prog_model
    import pps_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] bus,
    output pps_pins_s       pins
);
    initial pins = PINS_IDLE;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // Selects settle 4 clocks around each strobe edge
    task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
        pins.action_select_hi = act[1];
        pins.action_select_lo = act[0];
        pins.byte_select_one = bs1;
        pins.data = d;
        cyc(4);
        pins.load_strobe = 1'b1;
        cyc(4);
        pins.load_strobe = 1'b0;
        cyc(4);
    endtask : load
    task automatic wstrobe(input logic bs1, input logic bs2);
        pins.byte_select_one = bs1;
        pins.action_select_hi = bs2;
        cyc(4);
        pins.wr_n = 1'b0;
        cyc(4);
        pins.wr_n = 1'b1;
        cyc(4);
    endtask : wstrobe
    // Released bus shows inverted data, never a stale byte
    task automatic rd(input logic bs2, input logic bs1, output logic [7:0] d);
        pins.action_select_hi = bs2;
        pins.byte_select_one = bs1;
        pins.data = ~pins.data;
        pins.oe_n = 1'b0;
        cyc(10);
        d = bus;
        pins.oe_n = 1'b1;
        cyc(6);
    endtask : rd
endmodule : pps_prog_model

// File: tb/pps_seq_bench.sv
// Self-checking bench of the parallel programming sequencer.
// Assumes pps_prog_model as the programmer, shortened busy times.
`timescale 1ns/1ps
module pps_seq_bench
    import pps_pkg::*;
;
    localparam int PC = 1200;
    localparam int EC = 1500;
    localparam int SIGV[4] = '{8'h5a, 8'h3c, 8'h0f, 8'h80}; // Default identity bytes and calibration byte
    logic      clk;
    logic      nrst;
    pps_pins_s pins;
    logic [7:0] data_out, bus, d;
    logic      data_oe, rdy;
    int        mismatches, cmp_count, cyc_n, flo, fhi, lck, a, hi, lo, w, v, k, n;
    int        fl[int];
    int        ee[int];
    assign bus = data_oe ? data_out : pins.data;
    pps_seq #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) dut (.clk(clk), .nrst(nrst),
        .load_strobe(pins.load_strobe), .action_select_hi(pins.action_select_hi),
        .action_select_lo(pins.action_select_lo), .byte_select_one(pins.byte_select_one),
        .wr_n(pins.wr_n), .oe_n(pins.oe_n), .data_in(bus), .data_out(data_out),
        .data_oe(data_oe), .ready_busy_flag(rdy));
    pps_prog_model pm (.clk(clk), .bus(bus), .pins(pins));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n == 30000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input int exp, input logic [7:0] got);
        cmp_count++;
        if (got !== 8'(exp))
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, 8'(exp), got);
        end
    endtask : chk
    // Busy spans from the internal write edge, 5 clocks after the pin
    task automatic prog(input logic bs1, input logic bs2, input int exp);
        pm.wstrobe(bs1, bs2);
        n = 8;
        while (rdy !== 1'b1 && n < 4000)
        begin
            pm.cyc(1);
            n++;
        end
        cmp_count++;
        if (n - 5 < exp - 2 || n - 5 > exp + 2)
        begin
            mismatches++;
            $display("[FAIL] busy expected %0d seen %0d", exp, n - 5);
        end
    endtask : prog
    task automatic rdchk(input string what, input logic bs2, input logic bs1, input int exp);
        pm.rd(bs2, bs1, d);
        chk(what, exp, d);
    endtask : rdchk
    task automatic end_of_test();
        $display("Counts: %0d mismatches, %0d comparisons", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        nrst = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        cyc_n = 0;
        lck = 255;
        void'($urandom(81021));
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        pm.cyc(2);
        chk("ready", 1, {7'h0, rdy});
        chk("idle_out", 255, data_out);
        pm.load(ACT_CMD, 0, CMD_WFUSE);
        flo = $urandom_range(255);
        pm.load(ACT_DATA, 0, 8'(flo));
        prog(0, 0, PC);
        fhi = $urandom_range(255);
        pm.load(ACT_DATA, 0, 8'(fhi));
        prog(1, 0, PC);
        pm.load(ACT_CMD, 0, CMD_WLOCK);
        repeat (2)
        begin
            v = $urandom_range(255);
            lck &= v;
            pm.load(ACT_DATA, 0, 8'(v));
            prog(0, 0, PC);
        end
        for (k = 0; k < 2; k++)
        begin
            pm.load(ACT_CMD, 0, CMD_RFUSE);
            rdchk("fuse_lo", 0, 0, flo);
            rdchk("fuse_hi", 1, 1, fhi);
            rdchk("lock", 0, 1, lck);
            pm.load(ACT_CMD, 0, CMD_ERASE);
            if (k == 0)
                prog(0, 0, EC);
            lck = 255;
        end
        pm.load(ACT_CMD, 0, CMD_WFLASH);
        hi = $urandom_range(3);
        lo = $urandom_range(255) & 8'hf0;
        for (k = 0; k < 2; k++)
        begin
            w = $urandom_range(65535);
            fl[hi * 256 + lo + k * 15] = w;
            pm.load(ACT_ADDR, 0, 8'(lo + k * 15));
            pm.load(ACT_DATA, 0, 8'(w));
            pm.load(ACT_DATA, 1, 8'(w >> 8));
        end
        pm.load(ACT_ADDR, 1, 8'(hi));
        prog(0, 0, PC);
        pm.load(ACT_CMD, 0, CMD_NOP);
        pm.load(ACT_CMD, 0, CMD_RFLASH);
        pm.load(ACT_ADDR, 1, 8'(hi));
        for (k = 0; k < 3; k++)
        begin
            a = lo + ((k == 2) ? 15 : k);
            w = fl.exists(hi * 256 + a) ? fl[hi * 256 + a] : 65535;
            pm.load(ACT_ADDR, 0, 8'(a));
            rdchk("flash_lo", 0, 0, w & 255);
            rdchk("flash_hi", 0, 1, w >> 8);
        end
        pm.load(ACT_CMD, 0, CMD_WEE);
        a = $urandom_range(127) & 8'h7c;
        for (k = 0; k < 2; k++)
        begin
            v = $urandom_range(255);
            ee[a + k * 3] = v;
            pm.load(ACT_ADDR, 0, 8'(a + k * 3));
            pm.load(ACT_DATA, 0, 8'(v));
        end
        prog(0, 0, PC);
        pm.load(ACT_CMD, 0, CMD_REE);
        for (k = 0; k < 4; k++)
        begin
            pm.load(ACT_ADDR, 0, 8'(a + k));
            rdchk("eeprom", 0, 0, ee.exists(a + k) ? ee[a + k] : 255);
        end
        pm.load(ACT_CMD, 0, CMD_RSIG);
        for (k = 0; k < 3; k++)
        begin
            pm.load(ACT_ADDR, 0, 8'(k));
            rdchk("ident", 0, 0, SIGV[k]);
            rdchk("calib", 0, 1, SIGV[3]);
        end
        end_of_test();
    end
endmodule : pps_seq_bench
bind pps_seq pps_seq_props #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_props (
    .clk(clk), .nrst(nrst), .wr_n(wr_n), .oe_n(oe_n), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_flag(ready_busy_flag));
